// ### include/smx_pkg.sv
// Package: constants, types and register map of the instruction execution block
package smx_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SMX_OFF_CTRL     = 8'h00;
	localparam logic [7:0] SMX_OFF_THRESH   = 8'h04;
	localparam logic [7:0] SMX_OFF_PINMAP   = 8'h08;
	localparam logic [7:0] SMX_OFF_INTE     = 8'h0C;
	localparam logic [7:0] SMX_OFF_FLAGS    = 8'h10;
	localparam logic [7:0] SMX_OFF_DEBUG    = 8'h14;
	localparam logic [7:0] SMX_OFF_SHIFTCNT = 8'h18;
	localparam logic [7:0] SMX_OFF_X        = 8'h1C;
	localparam logic [7:0] SMX_OFF_Y        = 8'h20;
	localparam logic [7:0] SMX_OFF_ISR      = 8'h24;
	localparam logic [7:0] SMX_OFF_OSR      = 8'h28;

	// ----------------------------------------------------------------
	// Counts and reset values
	// ----------------------------------------------------------------
	localparam logic [5:0]  SMX_FULL_COUNT = 6'h20;
	localparam logic [31:0] SMX_CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] SMX_THRESH_RST = 32'h0000_0000;
	localparam logic [31:0] SMX_PINMAP_RST = 32'h0000_0000;
	localparam logic [31:0] SMX_INTE_RST   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Opcodes and field codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SMX_OP_FIFO = 3'h4;
	localparam logic [2:0] SMX_OP_COPY = 3'h5;
	localparam logic [2:0] SMX_OP_FLAG = 3'h6;
	localparam logic [2:0] SMX_OP_SET  = 3'h7;
	localparam logic [2:0] SMX_LOC_PINS = 3'h0;
	localparam logic [2:0] SMX_LOC_X    = 3'h1;
	localparam logic [2:0] SMX_LOC_Y    = 3'h2;
	localparam logic [2:0] SMX_LOC_NULL = 3'h3;
	localparam logic [2:0] SMX_LOC_EXECUTE_AS_INSTRUCTION = 3'h4;
	localparam logic [2:0] SMX_LOC_PC   = 3'h5;
	localparam logic [2:0] SMX_LOC_ISR  = 3'h6;
	localparam logic [2:0] SMX_LOC_OSR  = 3'h7;
	localparam logic [1:0] SMX_COP_INV  = 2'h1;
	localparam logic [1:0] SMX_COP_REV  = 2'h2;

	typedef enum logic [1:0] {
		SMX_IDLE     = 2'b00,
		SMX_EXECUTE_AS_INSTRUCTION     = 2'b01,
		SMX_FLAGWAIT = 2'b10,
		SMX_DELAY    = 2'b11
	} smx_fsm_e;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} smx_apb_req_s;

	// Whole state of the block
	typedef struct packed {
		smx_fsm_e    fsm;
		logic [15:0] cur;
		logic [4:0]  dly;
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] input_shift_reg;
		logic [31:0] output_shift_reg;
		logic [5:0]  isr_cnt;
		logic [5:0]  osr_cnt;
		logic [7:0]  flags;
		logic        rx_stall_debug_flag;
		logic [31:0] ctrl;
		logic [31:0] thresh;
		logic [31:0] pinmap;
		logic [31:0] inte;
		logic        instr_ready;
		logic        done;
		logic        stall;
		logic        rx_push;
		logic [31:0] rx_data;
		logic        tx_pop;
		logic        jump_valid;
		logic [4:0]  jump_pc;
		logic        fwd_valid;
		logic [15:0] fwd_instr;
		logic [31:0] pins_out;
		logic [31:0] pins_dir;
		logic        irq_line0;
		logic        irq_line1;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} smx_state_s;

	localparam smx_state_s SMX_STATE_RST = '0;

endpackage : smx_pkg

// ### verilog/smx_execute_as_instruction.sv
// Execution unit for FIFO store/load, copy, flag and immediate set instructions
// Notes on behaviour
// - Store moves whole input word, then clears.
// - Only-when-full store needs count at threshold.
// - Blocking store stalls while receive FIFO full.
// - Nonblocking full store: drop, clear, flag stall.
// - Load moves one transmit word to output.
// - Only-when-empty load needs count at threshold.
// - Blocking load stalls; else empty copies X.
// - Autopull: load is no-op while output full.
// - Copy destination code selects target.
// - Copy to shift registers resets its count.
// - Copy op: none, invert, bit reverse.
// - Copy source code selects origin.
// - Execute copy: word runs next cycle, no delay.
// - Status source is all ones or zeroes.
// - Flag raise or clear; clear ignores wait.
// - Wait holds until flag lowered, then delay.
// - Index MSB adds machine number modulo four.
// - Flags 0-3 reach two gated request lines.
// - Immediate five bits to pins, X, Y, dirs.
// - Set and output pin ranges configured apart.
// - Delay counts only after stall completes.
`timescale 1ns/10ps
`default_nettype none

module smx_execute_as_instruction (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire smx_pkg::smx_apb_req_s apb_req,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  instr_valid,
	input  wire logic [15:0]           instr,
	output logic                       instr_ready,
	output logic                       instr_done,
	output logic                       stall,
	input  wire logic                  rx_full,
	output logic                       rx_push,
	output logic [31:0]                rx_data,
	input  wire logic                  tx_empty,
	input  wire logic [31:0]           tx_data,
	output logic                       tx_pop,
	output logic                       jump_valid,
	output logic [4:0]                 jump_pc,
	output logic                       fwd_valid,
	output logic [15:0]                fwd_instr,
	input  wire logic [31:0]           pins_in,
	output logic [31:0]                pins_out,
	output logic [31:0]                pins_dir,
	output logic                       irq_line0,
	output logic                       irq_line1
);
	import smx_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] flag_index(input logic [4:0] f, input logic [1:0] sm);
		logic [1:0] lo;
		lo = f[1:0] + sm;
		flag_index = f[4] ? {f[2], lo} : f[2:0];
	endfunction : flag_index

	function automatic logic [5:0] thresh_count(input logic [4:0] f);
		thresh_count = (f == 5'h00) ? SMX_FULL_COUNT : {1'b0, f};
	endfunction : thresh_count

	// Write cnt low bits of val at base upward, modulo 32
	function automatic logic [31:0] map_out(input logic [31:0] old, input logic [31:0] val,
		input logic [4:0] base, input logic [5:0] cnt);
		logic [4:0] j;
		map_out = old;
		for (int i = 0; i < 32; i++) begin
			j = base + i[4:0];
			if (i[5:0] < cnt) begin
				map_out[j] = val[i];
			end
		end
	endfunction : map_out

	function automatic logic [31:0] map_in(input logic [31:0] p, input logic [4:0] base);
		logic [4:0] j;
		map_in = '0;
		for (int i = 0; i < 32; i++) begin
			j = base + i[4:0];
			map_in[i] = p[j];
		end
	endfunction : map_in

	function automatic logic [31:0] bit_rev(input logic [31:0] v);
		for (int i = 0; i < 32; i++) begin
			bit_rev[i] = v[31 - i];
		end
	endfunction : bit_rev

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	smx_state_s r_reg;
	smx_state_s r_next;

	logic [2:0]  op3;
	logic        fin;
	logic        stl;
	logic [31:0] src;
	logic [31:0] val;
	logic [5:0]  st_th;
	logic [5:0]  ld_th;
	logic [2:0]  fidx;
	logic        wr_acc;
	logic        autopull_en;
	logic [1:0]  sm_id;

	assign op3         = r_reg.cur[15:13];
	assign st_th       = thresh_count(r_reg.thresh[4:0]);
	assign ld_th       = thresh_count(r_reg.thresh[12:8]);
	assign fidx        = flag_index(r_reg.cur[4:0], sm_id);
	assign autopull_en = r_reg.ctrl[3];
	assign sm_id       = r_reg.ctrl[1:0];
	assign wr_acc      = apb_req.psel & apb_req.penable & r_reg.pready & apb_req.pwrite;

	always_comb begin
		r_next            = r_reg;
		fin               = 1'b0;
		stl               = 1'b0;
		src               = '0;
		val               = '0;
		r_next.done       = 1'b0;
		r_next.rx_push    = 1'b0;
		r_next.tx_pop     = 1'b0;
		r_next.jump_valid = 1'b0;
		r_next.fwd_valid  = 1'b0;

		// ------------------------------------------------------------
		// APB slave: answer in the first access cycle
		// ------------------------------------------------------------
		r_next.pready  = apb_req.psel & ~apb_req.penable;
		r_next.pslverr = 1'b0;
		if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
			unique case (apb_req.paddr)
				SMX_OFF_CTRL:     r_next.prdata = r_reg.ctrl;
				SMX_OFF_THRESH:   r_next.prdata = r_reg.thresh;
				SMX_OFF_PINMAP:   r_next.prdata = r_reg.pinmap;
				SMX_OFF_INTE:     r_next.prdata = r_reg.inte;
				SMX_OFF_FLAGS:    r_next.prdata = {24'h000000, r_reg.flags};
				SMX_OFF_DEBUG:    r_next.prdata = {31'h0, r_reg.rx_stall_debug_flag};
				SMX_OFF_SHIFTCNT: r_next.prdata = {18'h0, r_reg.osr_cnt, 2'h0, r_reg.isr_cnt};
				SMX_OFF_X:        r_next.prdata = r_reg.x;
				SMX_OFF_Y:        r_next.prdata = r_reg.y;
				SMX_OFF_ISR:      r_next.prdata = r_reg.input_shift_reg;
				SMX_OFF_OSR:      r_next.prdata = r_reg.output_shift_reg;
				default: begin
					r_next.prdata  = 32'h0000_0000;
					r_next.pslverr = 1'b1;
				end
			endcase
		end else if (apb_req.psel & ~apb_req.penable) begin
			r_next.pslverr = !(apb_req.paddr inside {SMX_OFF_CTRL, SMX_OFF_THRESH,
				SMX_OFF_PINMAP, SMX_OFF_INTE, SMX_OFF_FLAGS, SMX_OFF_DEBUG, SMX_OFF_SHIFTCNT,
				SMX_OFF_X, SMX_OFF_Y, SMX_OFF_ISR, SMX_OFF_OSR});
		end
		if (wr_acc) begin
			unique case (apb_req.paddr)
				SMX_OFF_CTRL:     r_next.ctrl   = apb_req.pwdata;
				SMX_OFF_THRESH:   r_next.thresh = apb_req.pwdata;
				SMX_OFF_PINMAP:   r_next.pinmap = apb_req.pwdata;
				SMX_OFF_INTE:     r_next.inte   = apb_req.pwdata;
				SMX_OFF_FLAGS:    r_next.flags  = r_reg.flags & ~apb_req.pwdata[7:0];
				SMX_OFF_DEBUG: begin
					if (apb_req.pwdata[0]) begin
						r_next.rx_stall_debug_flag = 1'b0;
					end
				end
				SMX_OFF_SHIFTCNT: begin
					r_next.isr_cnt = apb_req.pwdata[5:0];
					r_next.osr_cnt = apb_req.pwdata[13:8];
				end
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// Execution; hardware sets win over software clears above
		// ------------------------------------------------------------
		unique case (r_reg.fsm)
			SMX_IDLE: begin
				if (instr_valid) begin
					r_next.cur = instr;
					r_next.fsm = SMX_EXECUTE_AS_INSTRUCTION;
				end
			end
			SMX_EXECUTE_AS_INSTRUCTION: begin
				fin = 1'b1;
				unique case (op3)
					SMX_OP_FIFO: begin
						if (!r_reg.cur[7]) begin
							if (r_reg.cur[6] && (r_reg.isr_cnt < st_th)) begin
								// Only-when-full store below threshold does nothing
							end else if (rx_full) begin
								r_next.rx_stall_debug_flag = 1'b1;
								if (r_reg.cur[5]) begin
									fin = 1'b0;
									stl = 1'b1;
								end else begin
									r_next.input_shift_reg = '0;
									r_next.isr_cnt         = '0;
								end
							end else begin
								r_next.rx_push         = 1'b1;
								r_next.rx_data         = r_reg.input_shift_reg;
								r_next.input_shift_reg = '0;
								r_next.isr_cnt         = '0;
							end
						end else begin
							if (autopull_en && (r_reg.osr_cnt < ld_th)) begin
								// Barrier while output word still full
							end else if (r_reg.cur[6] && (r_reg.osr_cnt < ld_th)) begin
								// Only-when-empty load below threshold
							end else if (tx_empty) begin
								if (r_reg.cur[5]) begin
									fin = 1'b0;
									stl = 1'b1;
								end else begin
									r_next.output_shift_reg = r_reg.x;
									r_next.osr_cnt          = '0;
								end
							end else begin
								r_next.tx_pop           = 1'b1;
								r_next.output_shift_reg = tx_data;
								r_next.osr_cnt          = '0;
							end
						end
					end
					SMX_OP_COPY: begin
						unique case (r_reg.cur[2:0])
							SMX_LOC_PINS: src = map_in(pins_in, r_reg.ctrl[12:8]);
							SMX_LOC_X:    src = r_reg.x;
							SMX_LOC_Y:    src = r_reg.y;
							SMX_LOC_NULL: src = '0;
							SMX_LOC_EXECUTE_AS_INSTRUCTION: src = '0;
							SMX_LOC_PC:   src = {32{r_reg.ctrl[2] ? rx_full : tx_empty}};
							SMX_LOC_ISR:  src = r_reg.input_shift_reg;
							SMX_LOC_OSR:  src = r_reg.output_shift_reg;
						endcase
						unique case (r_reg.cur[4:3])
							SMX_COP_INV: val = ~src;
							SMX_COP_REV: val = bit_rev(src);
							default:     val = src;
						endcase
						unique case (r_reg.cur[7:5])
							SMX_LOC_PINS: r_next.pins_out = map_out(r_reg.pins_out, val,
								r_reg.pinmap[4:0], r_reg.pinmap[13:8]);
							SMX_LOC_X:    r_next.x = val;
							SMX_LOC_Y:    r_next.y = val;
							SMX_LOC_NULL: ;
							SMX_LOC_EXECUTE_AS_INSTRUCTION: begin
								r_next.cur = val[15:0];
								fin        = 1'b0;
							end
							SMX_LOC_PC: begin
								r_next.jump_valid = 1'b1;
								r_next.jump_pc    = val[4:0];
							end
							SMX_LOC_ISR: begin
								r_next.input_shift_reg = val;
								r_next.isr_cnt         = '0;
							end
							SMX_LOC_OSR: begin
								r_next.output_shift_reg = val;
								r_next.osr_cnt          = '0;
							end
						endcase
					end
					SMX_OP_FLAG: begin
						if (r_reg.cur[6]) begin
							r_next.flags[fidx] = 1'b0;
						end else begin
							r_next.flags[fidx] = 1'b1;
							if (r_reg.cur[5]) begin
								r_next.fsm = SMX_FLAGWAIT;
								fin        = 1'b0;
							end
						end
					end
					SMX_OP_SET: begin
						unique case (r_reg.cur[7:5])
							SMX_LOC_PINS: r_next.pins_out = map_out(r_reg.pins_out,
								{27'h0, r_reg.cur[4:0]}, r_reg.pinmap[20:16],
								{3'h0, r_reg.pinmap[26:24]});
							SMX_LOC_X:    r_next.x = {27'h0, r_reg.cur[4:0]};
							SMX_LOC_Y:    r_next.y = {27'h0, r_reg.cur[4:0]};
							SMX_LOC_EXECUTE_AS_INSTRUCTION: r_next.pins_dir = map_out(r_reg.pins_dir,
								{27'h0, r_reg.cur[4:0]}, r_reg.pinmap[20:16],
								{3'h0, r_reg.pinmap[26:24]});
							default: ;
						endcase
					end
					default: begin
						r_next.fwd_valid = 1'b1;
						r_next.fwd_instr = r_reg.cur;
					end
				endcase
			end
			SMX_FLAGWAIT: begin
				fin = !r_next.flags[fidx];
				stl = !fin;
			end
			SMX_DELAY: begin
				r_next.dly = r_reg.dly - 5'h01;
				if (r_reg.dly == 5'h01) begin
					r_next.done = 1'b1;
					r_next.fsm  = SMX_IDLE;
				end
			end
		endcase

		// Delay starts only once the instruction has completed
		if (fin) begin
			if (r_reg.cur[12:8] != 5'h00) begin
				r_next.dly = r_reg.cur[12:8];
				r_next.fsm = SMX_DELAY;
			end else begin
				r_next.done = 1'b1;
				r_next.fsm  = SMX_IDLE;
			end
		end
		r_next.stall       = stl;
		r_next.instr_ready = (r_next.fsm == SMX_IDLE);
		r_next.irq_line0   = |(r_next.flags[3:0] & r_next.inte[3:0]);
		r_next.irq_line1   = |(r_next.flags[3:0] & r_next.inte[11:8]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= SMX_STATE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata      = r_reg.prdata;
	assign pready      = r_reg.pready;
	assign pslverr     = r_reg.pslverr;
	assign instr_ready = r_reg.instr_ready;
	assign instr_done  = r_reg.done;
	assign stall       = r_reg.stall;
	assign rx_push     = r_reg.rx_push;
	assign rx_data     = r_reg.rx_data;
	assign tx_pop      = r_reg.tx_pop;
	assign jump_valid  = r_reg.jump_valid;
	assign jump_pc     = r_reg.jump_pc;
	assign fwd_valid   = r_reg.fwd_valid;
	assign fwd_instr   = r_reg.fwd_instr;
	assign pins_out    = r_reg.pins_out;
	assign pins_dir    = r_reg.pins_dir;
	assign irq_line0   = r_reg.irq_line0;
	assign irq_line1   = r_reg.irq_line1;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic ex_store;
	logic ex_load;
	assign ex_store = (r_reg.fsm == SMX_EXECUTE_AS_INSTRUCTION) && (op3 == SMX_OP_FIFO) && !r_reg.cur[7];
	assign ex_load  = (r_reg.fsm == SMX_EXECUTE_AS_INSTRUCTION) && (op3 == SMX_OP_FIFO) && r_reg.cur[7];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	store_clears_a: assert property (
		ex_store && !rx_full && !(r_reg.cur[6] && r_reg.isr_cnt < st_th)
		|=> rx_push && rx_data == $past(r_reg.input_shift_reg) && r_reg.input_shift_reg == '0)
		else $error("store did not move and clear the input word");
	iffull_gate_a: assert property (
		ex_store && r_reg.cur[6] && r_reg.isr_cnt < st_th
		|=> !rx_push && r_reg.input_shift_reg == $past(r_reg.input_shift_reg))
		else $error("only-when-full store acted below threshold");
	store_block_a: assert property (
		ex_store && r_reg.cur[5] && rx_full && !(r_reg.cur[6] && r_reg.isr_cnt < st_th)
		|=> !rx_push && r_reg.fsm == SMX_EXECUTE_AS_INSTRUCTION && stall)
		else $error("blocking store to full FIFO did not stall");
	store_drop_a: assert property (
		ex_store && !r_reg.cur[5] && !r_reg.cur[6] && rx_full
		|=> !rx_push && r_reg.rx_stall_debug_flag && r_reg.input_shift_reg == '0)
		else $error("nonblocking full store wrong");
	load_empty_a: assert property (
		ex_load && !r_reg.cur[5] && tx_empty && !autopull_en && !r_reg.cur[6]
		|=> !tx_pop && r_reg.output_shift_reg == $past(r_reg.x))
		else $error("nonblocking empty load did not copy X");
	load_barrier_a: assert property (
		ex_load && autopull_en && r_reg.osr_cnt < ld_th
		|=> !tx_pop && $stable(r_reg.output_shift_reg))
		else $error("load not a barrier under autopull");
	execute_as_instruction_next_a: assert property (
		r_reg.fsm == SMX_EXECUTE_AS_INSTRUCTION && op3 == SMX_OP_COPY && r_reg.cur[7:5] == SMX_LOC_EXECUTE_AS_INSTRUCTION
		|=> r_reg.fsm == SMX_EXECUTE_AS_INSTRUCTION && !instr_done)
		else $error("executed copy word did not run next cycle");
	set_scratch_a: assert property (
		r_reg.fsm == SMX_EXECUTE_AS_INSTRUCTION && op3 == SMX_OP_SET && r_reg.cur[7:5] == SMX_LOC_X
		|=> r_reg.x == {27'h0, $past(r_reg.cur[4:0])})
		else $error("immediate set of X wrong");
	flag_hold_a: assert property (
		r_reg.fsm == SMX_FLAGWAIT && r_next.flags[fidx]
		|=> r_reg.fsm == SMX_FLAGWAIT && !instr_done)
		else $error("flag wait ended while flag raised");
	irq_gate_a: assert property (
		irq_line0 == |(r_reg.flags[3:0] & r_reg.inte[3:0]))
		else $error("request line 0 does not follow enabled flags");

	store_cov_c: cover property (ex_store ##1 rx_push);
	flag_cov_c: cover property (r_reg.fsm == SMX_FLAGWAIT ##[1:50] instr_done);
	sequence execute_as_instruction_next_a_seq;
		r_reg.fsm == SMX_EXECUTE_AS_INSTRUCTION && op3 == SMX_OP_COPY && r_reg.cur[7:5] == SMX_LOC_EXECUTE_AS_INSTRUCTION ##1 instr_done;
	endsequence
	execute_as_instruction_cov_c: cover property (execute_as_instruction_next_a_seq);
	load_cov_c: cover property (ex_load && tx_empty && !r_reg.cur[5]);

endmodule : smx_execute_as_instruction

`default_nettype wire

// ### dv/smx_fifo_model.sv
// Far-side model: receive FIFO level and transmit FIFO words
`timescale 1ns/10ps
`default_nettype none

module smx_fifo_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       rx_block,
	input  wire logic [3:0] tx_fill,
	input  wire logic       tx_pop,
	output logic            rx_full,
	output logic            tx_empty,
	output logic [31:0]     tx_data
);
	logic [3:0] tx_left;
	logic [7:0] tx_idx;
	logic [7:0] cyc;

	assign rx_full  = rx_block;
	assign tx_empty = (tx_left == 4'h0);
	// Head word is meaningless while empty, so keep it moving
	assign tx_data  = tx_empty ? {4{cyc}} : {24'hA5_0000, tx_idx};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_left <= 4'h0;
			tx_idx  <= 8'h00;
			cyc     <= 8'h00;
		end else begin
			cyc <= cyc + 8'h01;
			if (tx_fill != 4'h0) begin
				tx_left <= tx_left + tx_fill;
			end else if (tx_pop && !tx_empty) begin
				tx_left <= tx_left - 4'h1;
				tx_idx  <= tx_idx + 8'h01;
			end
		end
	end
endmodule : smx_fifo_model

`default_nettype wire

// ### dv/test_sm_fifo_mov_irq_set_execute_as_instruction.sv
// Self-checking testbench of the instruction execution block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_sm_fifo_mov_irq_set_execute_as_instruction;
	import smx_pkg::*;
	logic        pclk, presetn, instr_valid, rx_block, rx_full, tx_empty, tx_pop;
	logic        pready, pslverr, instr_ready, instr_done, stall, rx_push;
	logic        jump_valid, fwd_valid, irq_line0, irq_line1;
	logic [15:0] instr, fwd_instr;
	logic [31:0] prdata, rx_data, tx_data, pins_in, pins_out, pins_dir, seed, vx, vy;
	logic [4:0]  jump_pc;
	logic [3:0]  tx_fill;
	logic [33:0] exp_rd[$], exp_ev[$];
	smx_apb_req_s req;
	int          num_errors, compares, cyc, i;

	smx_execute_as_instruction uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .instr_done(instr_done), .stall(stall),
		.rx_full(rx_full), .rx_push(rx_push), .rx_data(rx_data), .tx_empty(tx_empty),
		.tx_data(tx_data), .tx_pop(tx_pop), .jump_valid(jump_valid), .jump_pc(jump_pc),
		.fwd_valid(fwd_valid), .fwd_instr(fwd_instr), .pins_in(pins_in),
		.pins_out(pins_out), .pins_dir(pins_dir), .irq_line0(irq_line0),
		.irq_line1(irq_line1));
	smx_fifo_model far (.pclk(pclk), .presetn(presetn), .rx_block(rx_block),
		.tx_fill(tx_fill), .tx_pop(tx_pop), .rx_full(rx_full), .tx_empty(tx_empty),
		.tx_data(tx_data));

	always #5 pclk = ~pclk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [33:0] take(ref logic [33:0] q[$]);
		return (q.size() != 0) ? q.pop_front() : 34'hX;
	endfunction : take

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		req <= '0;
		// Idle cycle keeps the next setup off this edge
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
		exp_rd.push_back({1'b0, e, d});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic run(input logic [15:0] op);
		while (instr_ready !== 1'b1) @(posedge pclk);
		instr_valid <= 1'b1;
		instr       <= op;
		@(posedge pclk);
		instr_valid <= 1'b0;
		while (instr_done !== 1'b1) @(posedge pclk);
	endtask : run

	task automatic give();
		tx_fill <= 4'h1;
		@(posedge pclk);
		tx_fill <= 4'h0;
	endtask : give

	// ------------------------------------------------------------
	// Result watcher
	// ------------------------------------------------------------
	always @(posedge pclk) begin
		if (req.psel && req.penable && pready === 1'b1 && !req.pwrite)
			`CHK({1'b0, pslverr, prdata}, take(exp_rd))
		if (rx_push === 1'b1) `CHK({2'd0, rx_data}, take(exp_ev))
		if (jump_valid === 1'b1) `CHK({2'd1, 27'h0, jump_pc}, take(exp_ev))
		if (fwd_valid === 1'b1) `CHK({2'd2, 16'h0, fwd_instr}, take(exp_ev))
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		pclk = 0; presetn = 0; req = '0; instr_valid = 0; instr = '0;
		rx_block = 0; tx_fill = '0; seed = 32'h1937_7F91; num_errors = 0;
		compares = 0; cyc = 0;
		pins_in = xs();
		vx = xs() & 32'h0000_001F;
		vy = xs() & 32'h0000_001F;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		for (i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
		rd(8'h40, 32'h0, 1'b1);
		$display("test registers finished");
		wr(SMX_OFF_PINMAP, 32'h0500_0808);
		run(16'hE020 | 16'(vx)); rd(SMX_OFF_X, vx);
		run(16'hE040 | 16'(vy)); rd(SMX_OFF_Y, vy);
		run(16'hE000 | 16'(vy)); `CHK(pins_out[4:0], vy[4:0])
		run(16'hE080 | 16'(vx)); `CHK(pins_dir[4:0], vx[4:0])
		run(16'hA02A); rd(SMX_OFF_X, ~vy);
		run(16'hA032); rd(SMX_OFF_X, {<<{vy}});
		run(16'hA023); rd(SMX_OFF_X, 32'h0);
		run(16'hA020); rd(SMX_OFF_X, pins_in);
		wr(SMX_OFF_CTRL, 32'h0000_0006);
		for (i = 0; i < 2; i++) begin
			rx_block <= i[0];
			run(16'hA025); rd(SMX_OFF_X, {32{i[0]}});
		end
		rx_block <= 1'b0;
		run(16'hE020 | 16'(vx));
		exp_ev.push_back({2'd1, 27'h0, vy[4:0]});
		run(16'hA0A2);
		$display("test copy finished");
		wr(SMX_OFF_SHIFTCNT, 32'h0000_0505);
		run(16'hA0C1); rd(SMX_OFF_SHIFTCNT, 32'h0000_0500);
		run(16'hA0E1); rd(SMX_OFF_SHIFTCNT, 32'h0);
		exp_ev.push_back({2'd0, vx});
		run(16'h8020); rd(SMX_OFF_ISR, 32'h0);
		wr(SMX_OFF_THRESH, 32'h0000_1008);
		run(16'hA0C1); run(16'h8060); rd(SMX_OFF_ISR, vx);
		wr(SMX_OFF_SHIFTCNT, 32'h0000_0008);
		exp_ev.push_back({2'd0, vx});
		run(16'h8060); rd(SMX_OFF_ISR, 32'h0);
		rx_block <= 1'b1;
		run(16'hA0C1); run(16'h8000); rd(SMX_OFF_ISR, 32'h0);
		rd(SMX_OFF_DEBUG, 32'h1);
		wr(SMX_OFF_DEBUG, 32'h1);
		run(16'hA0C1);
		exp_ev.push_back({2'd0, vx});
		fork
			run(16'h8020);
			begin
				repeat (6) @(posedge pclk);
				`CHK(stall, 1'b1)
				rx_block <= 1'b0;
			end
		join
		wr(SMX_OFF_DEBUG, 32'h1);
		$display("test store finished");
		give(); run(16'h80A0); rd(SMX_OFF_OSR, 32'hA500_0000);
		run(16'h8080); rd(SMX_OFF_OSR, vx);
		give(); run(16'h80E0); rd(SMX_OFF_OSR, vx);
		wr(SMX_OFF_CTRL, 32'h0000_000E);
		run(16'h80A0); rd(SMX_OFF_OSR, vx);
		wr(SMX_OFF_SHIFTCNT, 32'h0000_1000);
		run(16'h80A0); rd(SMX_OFF_OSR, 32'hA500_0001);
		exp_ev.push_back({2'd2, 32'h0000_0001});
		run(16'hBF87);
		$display("test load finished");
		wr(SMX_OFF_INTE, 32'h0000_0201);
		run(16'hC012); rd(SMX_OFF_FLAGS, 32'h1);
		`CHK({irq_line1, irq_line0}, 2'b01)
		run(16'hC001); `CHK({irq_line1, irq_line0}, 2'b11)
		run(16'hC061); rd(SMX_OFF_FLAGS, 32'h1);
		run(16'hC004); rd(SMX_OFF_FLAGS, 32'h11);
		wr(SMX_OFF_FLAGS, 32'hFF); rd(SMX_OFF_FLAGS, 32'h0);
		`CHK({irq_line1, irq_line0}, 2'b00)
		fork
			run(16'hC322);
			begin
				repeat (6) @(posedge pclk);
				`CHK(stall, 1'b1)
				wr(SMX_OFF_FLAGS, 32'h4);
			end
		join
		rd(SMX_OFF_FLAGS, 32'h0);
		`CHK(exp_ev.size(), 0)
		$display("test flags finished");
		end_of_test();
	end
endmodule : test_sm_fifo_mov_irq_set_execute_as_instruction

`default_nettype wire
